/* bench/rxb_checker_properties.sv */
// Port checker for the receive back end, bound to its top module
`timescale 1ns/10ps
module rxb_checker #(
    parameter LANES = 2,
    parameter CHANNELS = 1
) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire [31:0] paddr, // APB address
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [31:0] pwdata, // APB write data
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire dec_valid, // Word valid
    input wire fabric_rd_en, // Pop
    input wire [LANES*CHANNELS-1:0] disparity_error_flag, // Disparity flags
    input wire [LANES*CHANNELS-1:0] code_error_flag, // Error flags
    input wire byte_order_restart, // Restart pin
    input wire byte_order_found, // Pattern found
    input wire phase_fifo_error, // FIFO full or empty
    input wire [1:0] read_clock_select // Read clock source
);
    // *****
    // Helpers
    // *****
    reg [2:0] ctl_r;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_r <= 3'h0;
        else if (psel && penable && pwrite && paddr[11:0] == 12'h000)
            ctl_r <= pwdata[3:1];
    end
    // External clock outranks bonding, bonding outranks rate match
    wire [1:0] sel_exp = ctl_r[2] ? 2'h3 : (ctl_r[0] ? 2'h2 : {1'h0, ctl_r[1]});
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // *****
    // Properties
    // *****
    sequence s_pin_rise;
        $rose(byte_order_restart);
    endsequence
    sequence s_drain;
        (fabric_rd_en && !dec_valid) [*4];
    endsequence
    property p_pair;
        (disparity_error_flag & ~code_error_flag) == '0;
    endproperty
    a_pair: assert property (p_pair) else $error("disparity without error flag");
    property p_set_cause;
        $rose(byte_order_found) |-> $past(dec_valid);
    endproperty
    a_set_cause: assert property (p_set_cause) else $error("found without word");
    property p_sync_hold;
        s_pin_rise ##0 byte_order_found |=> byte_order_found;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("restart too early");
    property p_restart;
        s_pin_rise |-> ##3 !byte_order_found;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not taken");
    property p_drain;
        s_drain |=> phase_fifo_error;
    endproperty
    a_drain: assert property (p_drain) else $error("no error when drained");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_slverr;
        psel && penable |-> pslverr == (paddr[11:0] > 12'h014 || paddr[1:0] != 2'h0);
    endproperty
    a_slverr: assert property (p_slverr) else $error("wrong slave error");
    property p_clksel;
        read_clock_select == sel_exp;
    endproperty
    a_clksel: assert property (p_clksel) else $error("wrong read clock");
endmodule // rxb_checker
bind rxb_decode_order rxb_checker #(.LANES(LANES), .CHANNELS(CHANNELS)) i_chk (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr, .dec_valid, .fabric_rd_en,
    .disparity_error_flag, .code_error_flag, .byte_order_restart, .byte_order_found,
    .phase_fifo_error, .read_clock_select);

/* bench/rxb_decode_order_tb.sv */
// Self-checking testbench of the receive back end
`timescale 1ns/10ps
module rxb_decode_order_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dec_valid, want, irq;
    logic byte_order_restart, fabric_rd_en, byte_order_found, phase_fifo_error, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] dec_data, fabric_parallel_out;
    logic [1:0] dec_is_k, dec_code_viol, dec_disp_mis, dec_rd_neg, read_clock_select;
    logic [1:0] control_code_flag, disparity_error_flag, code_error_flag;
    logic [1:0] running_disparity_negative;
    logic [23:0] q[$];
    int n_fail, total_checks;
    rxb_decode_order i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .dec_valid, .dec_data, .dec_is_k, .dec_code_viol,
        .dec_disp_mis, .dec_rd_neg, .byte_order_restart, .fabric_rd_en, .fabric_parallel_out,
        .control_code_flag, .disparity_error_flag, .code_error_flag,
        .running_disparity_negative, .byte_order_found, .phase_fifo_error,
        .read_clock_select, .irq);
    rxb_fabric_model i_fab (.pclk, .want, .fabric_rd_en);
    // *****
    // Shared tasks
    // *****
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, 20'h0, a, wd};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        for (i = 0; i < 8 && pready !== 1'h1; i++)
            @(posedge pclk);
        if (i == 8)
        begin
            n_fail++;
            end_of_test;
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Bench copy of the FIFO: a word offered while four are held is lost
    task push(input int n, input int s, input logic [7:0] lo);
        logic [7:0] i;
        @(posedge pclk);
        for (int j = 0; j < n; j++)
        begin
            i = 8'(s + j);
            dec_valid <= 1'h1;
            {dec_data, dec_is_k, dec_code_viol} <= {8'ha0 + i, lo + i, ~i[1:0], i[2:1]};
            {dec_disp_mis, dec_rd_neg} <= {i[1:0], i[1:0] ^ 2'h2};
            if (q.size() < 4)
                q.push_back({8'ha0 + i, lo + i, ~i[1:0], i[2:1] | i[1:0], i[1:0], i[1:0] ^ 2'h2});
            @(posedge pclk);
        end
        dec_valid <= 1'h0;
    endtask
    task pop(input int n);
        @(posedge pclk);
        want <= 1'h1;
        for (int j = 0; j < n; j++)
        begin
            @(posedge pclk);
            if (j == n - 1)
                want <= 1'h0;
            @(negedge pclk);
            chk({fabric_parallel_out, control_code_flag, code_error_flag, disparity_error_flag,
                running_disparity_negative}, q.pop_front());
        end
    endtask
    // *****
    // Scenarios
    // *****
    task t_regs;
        rdchk(12'h000, 32'h0);
        chk(read_clock_select, 2'h0);
        rdchk(12'h004, 32'ha);
        rdchk(12'h00c, 32'h0);
        rdchk(12'h010, 32'hbc);
        rdchk(12'h018, 32'h0);
        chk(err, 1'h1);
        for (int j = 0; j < 3; j++)
        begin
            apb(1'h1, 12'h000, 32'h2 << j);
            @(negedge pclk);
            chk(read_clock_select, j == 0 ? 2'h2 : (j == 1 ? 2'h1 : 2'h3));
        end
        apb(1'h1, 12'h000, 32'h0);
        $display("regs test done");
    endtask
    task t_data;
        chk($bits(fabric_parallel_out), 16);
        push(3, 0, 8'h50);
        @(negedge pclk);
        chk(phase_fifo_error, 1'h0);
        pop(3);
        chk(phase_fifo_error, 1'h1);
        $display("data test done");
    endtask
    task t_fill;
        push(5, 4, 8'h40);
        @(negedge pclk);
        chk(phase_fifo_error, 1'h1);
        rdchk(12'h004, 32'h6);
        pop(4);
        rdchk(12'h004, 32'ha);
        $display("fill test done");
    endtask
    task t_order;
        chk(byte_order_found, 1'h0);
        push(1, 0, 8'hbc);
        @(posedge pclk);
        @(negedge pclk);
        chk(byte_order_found, 1'h1);
        @(posedge pclk);
        byte_order_restart <= 1'h1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(byte_order_found, 1'h1);
        @(negedge pclk);
        chk(byte_order_found, 1'h0);
        push(1, 0, 8'hbc);
        repeat (4) @(posedge pclk);
        byte_order_restart <= 1'h0;
        repeat (4) @(negedge pclk);
        chk(byte_order_found, 1'h1);
        apb(1'h1, 12'h000, 32'h1);
        repeat (3) @(negedge pclk);
        chk(byte_order_found, 1'h0);
        apb(1'h1, 12'h000, 32'h0);
        pop(2);
        $display("order test done");
    endtask
    task t_irq;
        rdchk(12'h008, 32'hf);
        chk(irq, 1'h0);
        apb(1'h1, 12'h00c, 32'h1);
        @(negedge pclk);
        chk(irq, 1'h1);
        apb(1'h1, 12'h008, 32'hf);
        @(negedge pclk);
        chk(irq, 1'h0);
        rdchk(12'h008, 32'h0);
        $display("irq test done");
    endtask
    initial
    begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, dec_valid, dec_data} = '0;
        {dec_is_k, dec_code_viol, dec_disp_mis, dec_rd_neg, byte_order_restart, want} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_data;
        t_fill;
        t_order;
        t_irq;
        end_of_test;
    end
    initial
    begin
        #400000;
        n_fail++;
        end_of_test;
    end
endmodule // rxb_decode_order_tb

/* bench/rxb_fabric_model.sv */
// Fabric-side consumer model that pops words from the phase FIFO
`timescale 1ns/10ps
module rxb_fabric_model (
    input wire logic pclk, // Fabric clock, the FIFO write clock itself
    input wire logic want, // Bench asks for one word per cycle
    output wire logic fabric_rd_en // Pop request to the block
);
    // No own clock: reading on the write clock keeps zero frequency offset
    assign fabric_rd_en = want;
endmodule // rxb_fabric_model

/* hdl/rxb_decode_order.v */
// Receive back end: decoder flags, byte ordering, phase FIFO and APB registers
//
// Function
// - Control flag high for K, low for D
// - Disparity flag set on disparity mismatch
// - Code/disparity pair reads 00, 10, 11
// - Running disparity flag high when negative
// - One status bit per byte lane
// - Rising restart edge restarts byte ordering
// - Found raised on pattern in low byte
// - No external clock: internal read clock chosen
// - Bonded configuration uses bonded core clock
// - Unbonded without rate match uses recovered
// - Unbonded with rate match uses local
// - Output width is lane width times lanes times channels
// - FIFO error while full or empty
`timescale 1ns/10ps
`include "rxb_regs.vh"
module rxb_decode_order #(
    parameter LANES = 2,
    parameter CHANNELS = 1,
    parameter FIFO_DEPTH_LOG2 = 2
) (
    input wire pclk, // Block clock, 25 MHz
    input wire presetn, // Asynchronous reset, active low
    input wire [31:0] paddr, // APB address
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error
    input wire dec_valid, // Decoded word valid
    input wire [8*LANES*CHANNELS-1:0] dec_data, // Decoded data bytes
    input wire [LANES*CHANNELS-1:0] dec_is_k, // Lane holds a K symbol
    input wire [LANES*CHANNELS-1:0] dec_code_viol, // Lane holds an invalid code group
    input wire [LANES*CHANNELS-1:0] dec_disp_mis, // Lane had a disparity mismatch
    input wire [LANES*CHANNELS-1:0] dec_rd_neg, // Lane decoded under negative disparity
    input wire byte_order_restart, // Asynchronous byte ordering restart
    input wire fabric_rd_en, // Fabric reads one word
    output wire [8*LANES*CHANNELS-1:0] fabric_parallel_out, // Word to the fabric
    output wire [LANES*CHANNELS-1:0] control_code_flag, // K symbol per lane
    output wire [LANES*CHANNELS-1:0] disparity_error_flag, // Disparity error per lane
    output wire [LANES*CHANNELS-1:0] code_error_flag, // Code or disparity error per lane
    output wire [LANES*CHANNELS-1:0] running_disparity_negative, // Negative disparity per lane
    output reg byte_order_found, // Ordering pattern detected
    output wire phase_fifo_error, // FIFO full or empty
    output wire [1:0] read_clock_select, // Chosen FIFO read clock source
    output wire irq // Level interrupt
);
    // ********************************
    // Widths
    // ********************************
    localparam NL = LANES * CHANNELS;
    localparam DW = 8 * NL;
    localparam FW = DW + 4 * NL;

    // ********************************
    // Functions
    // ********************************
    // Offset match on the low address bits, the only ones decoded
    function reg_hit;
        input [31:0] addr;
        input [11:0] ofs;
        begin
            reg_hit = (addr[11:0] == ofs);
        end
    endfunction

    // Invalid code group or disparity mismatch, the combined error of each lane
    function [NL-1:0] lane_err;
        input [NL-1:0] viol;
        input [NL-1:0] mis;
        begin
            lane_err = viol | mis;
        end
    endfunction

    // ********************************
    // Registers
    // ********************************
    reg [3:0] ctrl_r;
    reg [7:0] pattern_r;
    reg [`RXB_IRQ_W-1:0] irq_stat_r;
    reg [`RXB_IRQ_W-1:0] irq_mask_r;
    reg [`RXB_IRQ_W-1:0] irq_stat_nxt;
    reg [1:0] restart_sync_r;
    reg restart_prev_r;
    reg sw_restart_prev_r;
    reg found_prev_r;
    reg err_prev_r;
    reg [4*NL-1:0] lane_stat_r;
    wire restart_edge;
    wire fifo_full;
    wire fifo_empty;
    wire [FW-1:0] fifo_in;
    wire [FW-1:0] fifo_out;
    wire [NL-1:0] err_any;
    wire wr_access;
    wire rd_access;
    wire code_evt;
    wire disp_evt;

    // ********************************
    // Read clock choice
    // ********************************
    // One block clock stands for every source; the code reports which source a real
    // channel would use so fabric logic can check its clocking plan
    assign read_clock_select = ctrl_r[`RXB_CTRL_EXT_RDCLK_BIT] ? `RXB_CLK_EXTERNAL :
        ctrl_r[`RXB_CTRL_BONDED_BIT] ? `RXB_CLK_BONDED :
        ctrl_r[`RXB_CTRL_RATE_MATCH_BIT] ? `RXB_CLK_LOCAL_TX :
        `RXB_CLK_RECOVERED;

    // ********************************
    // Byte ordering
    // ********************************
    // Restart comes from another domain, so only the second stage is used
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            restart_sync_r <= 2'h0;
            restart_prev_r <= 1'b0;
            sw_restart_prev_r <= 1'b0;
        end
        else
        begin
            restart_sync_r <= {restart_sync_r[0], byte_order_restart};
            restart_prev_r <= restart_sync_r[1];
            sw_restart_prev_r <= ctrl_r[`RXB_CTRL_RESTART_BIT];
        end
    end

    assign restart_edge = (restart_sync_r[1] && !restart_prev_r) ||
        (ctrl_r[`RXB_CTRL_RESTART_BIT] && !sw_restart_prev_r);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_order_found <= 1'b0;
        end
        else if (restart_edge)
        begin
            byte_order_found <= 1'b0;
        end
        else if (dec_valid && dec_data[7:0] == pattern_r)
        begin
            byte_order_found <= 1'b1;
        end
    end

    // ********************************
    // Phase FIFO
    // ********************************
    // Flags ride in the same entry as the data so they never slip against it
    assign fifo_in = {dec_rd_neg, err_any, dec_disp_mis,
        dec_is_k, dec_data};

    rxb_phase_fifo #(
        .WIDTH(FW),
        .DEPTH_LOG2(FIFO_DEPTH_LOG2)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(dec_valid),
        .wr_data(fifo_in),
        .rd_en(fabric_rd_en),
        .rd_data(fifo_out),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    assign fabric_parallel_out = fifo_out[DW-1:0];
    assign control_code_flag = fifo_out[DW +: NL];
    assign disparity_error_flag = fifo_out[DW+NL +: NL];
    assign code_error_flag = fifo_out[DW+2*NL +: NL];
    assign running_disparity_negative = fifo_out[DW+3*NL +: NL];
    assign phase_fifo_error = fifo_full || fifo_empty;
    assign err_any = lane_err(dec_code_viol, dec_disp_mis);

    // ********************************
    // Interrupt events
    // ********************************
    assign code_evt = dec_valid && (|dec_code_viol);
    assign disp_evt = dec_valid && (|dec_disp_mis);
    // Level output: stays high until software clears or masks the source
    assign irq = |(irq_stat_r & irq_mask_r);

    // ********************************
    // APB slave
    // ********************************
    // Zero wait states; unmapped offsets read zero and flag an error
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && !pwrite;
    assign pready = 1'b1;
    // Writes to read-only or unmapped offsets are dropped
    assign pslverr = psel && penable && !(reg_hit(paddr, `RXB_CTRL_OFS) ||
        reg_hit(paddr, `RXB_STAT_OFS) || reg_hit(paddr, `RXB_IRQ_STAT_OFS) ||
        reg_hit(paddr, `RXB_IRQ_MASK_OFS) || reg_hit(paddr, `RXB_PATTERN_OFS) ||
        reg_hit(paddr, `RXB_LANE_STAT_OFS));

    always @*
    begin
        irq_stat_nxt = irq_stat_r;
        if (wr_access && paddr[11:0] == `RXB_IRQ_STAT_OFS)
        begin
            irq_stat_nxt = irq_stat_r & ~pwdata[`RXB_IRQ_W-1:0];
        end
        // Set after clear so a simultaneous event is kept
        if (byte_order_found && !found_prev_r)
        begin
            irq_stat_nxt[`RXB_IRQ_FOUND_BIT] = 1'b1;
        end
        if (phase_fifo_error && !err_prev_r)
        begin
            irq_stat_nxt[`RXB_IRQ_FIFO_ERR_BIT] = 1'b1;
        end
        if (code_evt)
        begin
            irq_stat_nxt[`RXB_IRQ_CODE_ERR_BIT] = 1'b1;
        end
        if (disp_evt)
        begin
            irq_stat_nxt[`RXB_IRQ_DISP_ERR_BIT] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= `RXB_CTRL_RESET;
            pattern_r <= `RXB_PATTERN_RESET;
            irq_mask_r <= `RXB_IRQ_MASK_RESET;
            irq_stat_r <= {`RXB_IRQ_W{1'b0}};
            found_prev_r <= 1'b0;
            // FIFO starts empty, so reset release must not look like an error edge
            err_prev_r <= 1'b1;
            lane_stat_r <= {(4*NL){1'b0}};
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            found_prev_r <= byte_order_found;
            err_prev_r <= phase_fifo_error;
            if (dec_valid)
            begin
                lane_stat_r <= {dec_rd_neg, err_any, dec_disp_mis, dec_is_k};
            end
            if (wr_access && paddr[11:0] == `RXB_CTRL_OFS)
            begin
                ctrl_r <= pwdata[3:0];
            end
            else if (wr_access && paddr[11:0] == `RXB_IRQ_MASK_OFS)
            begin
                irq_mask_r <= pwdata[`RXB_IRQ_W-1:0];
            end
            else if (wr_access && paddr[11:0] == `RXB_PATTERN_OFS)
            begin
                pattern_r <= pwdata[7:0];
            end
        end
    end

    always @*
    begin
        prdata = 32'h0000_0000;
        if (rd_access && paddr[11:0] == `RXB_CTRL_OFS)
        begin
            prdata[3:0] = ctrl_r;
        end
        else if (rd_access && paddr[11:0] == `RXB_STAT_OFS)
        begin
            prdata[`RXB_STAT_FOUND_BIT] = byte_order_found;
            prdata[`RXB_STAT_FIFO_ERR_BIT] = phase_fifo_error;
            prdata[`RXB_STAT_FULL_BIT] = fifo_full;
            prdata[`RXB_STAT_EMPTY_BIT] = fifo_empty;
            prdata[`RXB_STAT_CLKSEL_LSB +: 2] = read_clock_select;
        end
        else if (rd_access && paddr[11:0] == `RXB_IRQ_STAT_OFS)
        begin
            prdata[`RXB_IRQ_W-1:0] = irq_stat_r;
        end
        else if (rd_access && paddr[11:0] == `RXB_IRQ_MASK_OFS)
        begin
            prdata[`RXB_IRQ_W-1:0] = irq_mask_r;
        end
        else if (rd_access && paddr[11:0] == `RXB_PATTERN_OFS)
        begin
            prdata[7:0] = pattern_r;
        end
        else if (rd_access && paddr[11:0] == `RXB_LANE_STAT_OFS)
        begin
            prdata[4*NL-1:0] = lane_stat_r;
        end
    end
endmodule // rxb_decode_order

/* hdl/rxb_phase_fifo.v */
// Phase compensation FIFO carrying data words with their lane status bits
`timescale 1ns/10ps
module rxb_phase_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH_LOG2 = 2
) (
    input wire pclk, // Block clock
    input wire presetn, // Asynchronous reset, active low
    input wire wr_en, // Write enable from the selected write clock
    input wire [WIDTH-1:0] wr_data, // Word to store
    input wire rd_en, // Read enable from the selected read clock
    output reg [WIDTH-1:0] rd_data, // Word read out
    output wire full, // No free entry
    output wire empty // No stored entry
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [DEPTH_LOG2:0] wr_ptr_r;
    reg [DEPTH_LOG2:0] rd_ptr_r;
    wire do_wr;
    wire do_rd;

    assign full = (wr_ptr_r[DEPTH_LOG2] != rd_ptr_r[DEPTH_LOG2]) &&
                  (wr_ptr_r[DEPTH_LOG2-1:0] == rd_ptr_r[DEPTH_LOG2-1:0]);
    assign empty = (wr_ptr_r == rd_ptr_r);
    // Overflowing writes and underflowing reads are dropped; the error flag reports them
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;

    always @(posedge pclk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_r[DEPTH_LOG2-1:0]] <= wr_data;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
            rd_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
            rd_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
                rd_data <= mem[rd_ptr_r[DEPTH_LOG2-1:0]];
            end
        end
    end
endmodule // rxb_phase_fifo

/* hdl/rxb_regs.vh */
// Register offsets, field positions and reset values for the receive back end
`ifndef RXB_REGS_VH
`define RXB_REGS_VH
// APB byte offsets
`define RXB_CTRL_OFS 12'h000
`define RXB_STAT_OFS 12'h004
`define RXB_IRQ_STAT_OFS 12'h008
`define RXB_IRQ_MASK_OFS 12'h00c
`define RXB_PATTERN_OFS 12'h010
`define RXB_LANE_STAT_OFS 12'h014
// Control fields
`define RXB_CTRL_RESTART_BIT 0
`define RXB_CTRL_BONDED_BIT 1
`define RXB_CTRL_RATE_MATCH_BIT 2
`define RXB_CTRL_EXT_RDCLK_BIT 3
`define RXB_CTRL_RESET 4'h0
// Status fields
`define RXB_STAT_FOUND_BIT 0
`define RXB_STAT_FIFO_ERR_BIT 1
`define RXB_STAT_FULL_BIT 2
`define RXB_STAT_EMPTY_BIT 3
`define RXB_STAT_CLKSEL_LSB 4
// Interrupt events
`define RXB_IRQ_FOUND_BIT 0
`define RXB_IRQ_FIFO_ERR_BIT 1
`define RXB_IRQ_CODE_ERR_BIT 2
`define RXB_IRQ_DISP_ERR_BIT 3
`define RXB_IRQ_W 4
`define RXB_IRQ_MASK_RESET 4'h0
`define RXB_PATTERN_RESET 8'hbc
// Read clock source codes
`define RXB_CLK_RECOVERED 2'h0
`define RXB_CLK_LOCAL_TX 2'h1
`define RXB_CLK_BONDED 2'h2
`define RXB_CLK_EXTERNAL 2'h3
`endif
